// ---- pkg/fmrs_pkg.sv ----
// Purpose: Shared types and constants for the fieldbus master run/stop control.
// Assumes: One 25 MHz clock; host side delivers configuration and process data as words.
// Notes:   The bit rate index selects a divider count; all counts are in clock cycles.
package fmrs_pkg;
  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int unsigned MAX_STATIONS = 126;
  localparam int unsigned ADDR_W       = 7;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned LEN_W        = 8;
  localparam int unsigned RATE_W       = 4;
  localparam int unsigned CLK_HZ       = 25000000;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 7'h7d;

  // ************************************************************
  // Bit rate table, in bits per second
  // ************************************************************
  localparam int unsigned RATE_MIN_BPS = 9600;
  localparam int unsigned RATE_MAX_BPS = 12000000;
  localparam logic [RATE_W-1:0] RATE_IDX_MAX = 4'h9;

  // ************************************************************
  // Global control commands and telegram kinds
  // ************************************************************
  typedef enum logic [1:0] {
    FMRS_GC_NONE,
    FMRS_GC_CLEAR,
    FMRS_GC_OPERATE
  } fmrs_gc_t;

  typedef enum logic [1:0] {
    FMRS_TG_DATA,
    FMRS_TG_GLOBAL,
    FMRS_TG_SELF
  } fmrs_tg_t;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] own_addr;
    logic [RATE_W-1:0] rate_idx;
  } fmrs_bus_par_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              present;
    logic              fail_safe;
    logic [LEN_W-1:0]  out_len;
  } fmrs_slave_cfg_t;

  typedef struct packed {
    fmrs_tg_t          kind;
    fmrs_gc_t          gc;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0]  len;
    logic              zero_data;
  } fmrs_tel_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LEN_W-1:0]  idx;
  } fmrs_in_word_t;

  // Cycles of the clock per bit at the selected rate.
  function automatic logic [11:0] fmrs_bit_div(input logic [RATE_W-1:0] idx);
    logic [11:0] d;
    d = 12'h000;
    case (idx)
      4'h0:    d = 12'h0a2;
      4'h1:    d = 12'h051;
      4'h2:    d = 12'h029;
      4'h3:    d = 12'h015;
      4'h4:    d = 12'h00d;
      4'h5:    d = 12'h005;
      4'h6:    d = 12'h004;
      4'h7:    d = 12'h003;
      4'h8:    d = 12'h002;
      default: d = 12'h001;
    endcase
    return d;
  endfunction : fmrs_bit_div
endpackage : fmrs_pkg

// ---- design/fmrs_skid.sv ----
// Purpose: Two-entry buffer for returned slave input words.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Full only when both entries hold data; ready reflects that.
`timescale 1ns/1ns
module fmrs_skid (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire fmrs_pkg::fmrs_in_word_t in_data,
  input  wire logic                    in_valid,
  output wire logic                    in_ready,
  output wire fmrs_pkg::fmrs_in_word_t out_data,
  output wire logic                    out_valid,
  input  wire logic                    out_ready
);
  import fmrs_pkg::*;

  fmrs_in_word_t mem_q [2];
  logic          wr_q;
  logic          rd_q;
  logic [1:0]    cnt_q;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wr_q  <= wr_q ^ push;
      rd_q  <= rd_q ^ pop;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : fmrs_skid

// ---- design/fmrs_ctrl.sv ----
// Purpose: Operating state of the fieldbus master and its slave handling in host STOP and RUN.
// Assumes: The telegram engine accepts one telegram per tel_valid/tel_ready handshake.
// Notes:   Output bytes are fetched from the host image by the engine; zero_data forces them to zero.
// Summary of operation
// - After power-up without parameters the master stays inactive, all indicators dark.
// - Delivered bus parameters take the master online, shown on the run indicator.
// - Online without slave project, the master answers at its own address.
// - Valid configuration starts cyclic data exchange and lights the exchange indicator.
// - Parameters and configuration reload at power-up and on a new configuration during data exchange.
// - Host STOP broadcasts Clear; slaves then switch their outputs off.
// - In STOP fail-safe slaves get output telegrams of length zero.
// - In STOP other slaves get full-length telegrams with all data zero.
// - In STOP slave inputs are still polled and written to host inputs.
// - Host RUN broadcasts Operate; slaves then switch their outputs on.
// - In RUN each slave gets current output data; inputs go to host.
// - Addressing and bookkeeping cover up to 126 stations.
// - One common bit rate is selectable, from 162 down to 1 clock cycles per bit (about 154 kbit/s to 25 Mbit/s).
`timescale 1ns/1ns
module fmrs_ctrl (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     new_hw_cfg,
  input  wire fmrs_pkg::fmrs_bus_par_t  bus_par,
  input  wire logic                     bus_par_valid,
  input  wire fmrs_pkg::fmrs_slave_cfg_t slave_cfg,
  input  wire logic                     slave_cfg_wr,
  input  wire logic                     cfg_done,
  input  wire logic                     host_run,
  output wire fmrs_pkg::fmrs_tel_t      tel,
  output wire logic                     tel_valid,
  input  wire logic                     tel_ready,
  input  wire logic                     self_req,
  output wire logic                     bit_tick,
  input  wire fmrs_pkg::fmrs_in_word_t  rx_word,
  input  wire logic                     rx_valid,
  output wire logic                     rx_ready,
  output wire fmrs_pkg::fmrs_in_word_t  host_in,
  output wire logic                     host_in_valid,
  input  wire logic                     host_in_ready,
  output wire logic                     run_led,
  output wire logic                     data_exchange_indicator,
  output wire logic                     master_active
);
  import fmrs_pkg::*;

  // ************************************************************
  // Operating state
  // ************************************************************
  typedef enum logic [1:0] {
    FMRS_OFF,
    FMRS_ONLINE,
    FMRS_EXCHANGE
  } fmrs_op_t;

  typedef enum logic [1:0] {
    FMRS_CY_GLOBAL,
    FMRS_CY_SLAVE,
    FMRS_CY_SELF
  } fmrs_cy_t;

  fmrs_op_t          op_q;
  fmrs_op_t          op_d;
  fmrs_cy_t          cy_q;
  fmrs_cy_t          cy_d;
  fmrs_bus_par_t     par_q;
  logic              run_q;
  logic [ADDR_W-1:0] slot_q;
  logic [11:0]       div_q;
  logic              present_q   [MAX_STATIONS];
  logic              fail_safe_q [MAX_STATIONS];
  logic [LEN_W-1:0]  out_len_q   [MAX_STATIONS];
  fmrs_tel_t         tel_q;
  logic              tel_valid_q;

  wire start_cyc = (cy_q == FMRS_CY_GLOBAL) && !tel_valid_q;
  wire tel_fire  = tel_valid_q && tel_ready;
  wire slot_last = (slot_q == LAST_ADDR);
  wire cur_pres  = present_q[slot_q];
  // A pending offer is withdrawn when the master drops out, so nothing is offered while inactive.
  wire going_off = (op_d == FMRS_OFF);

  always_comb begin
    op_d = op_q;
    case (op_q)
      FMRS_OFF:      if (bus_par_valid) op_d = FMRS_ONLINE;
      FMRS_ONLINE:   if (cfg_done) op_d = FMRS_EXCHANGE;
      FMRS_EXCHANGE: if (new_hw_cfg) op_d = FMRS_OFF;
      default:       op_d = FMRS_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      op_q  <= FMRS_OFF;
      par_q <= '0;
    end else begin
      op_q <= op_d;
      if (bus_par_valid) begin
        par_q <= bus_par;
      end
    end
  end

  // Slave table, indexed by station address.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MAX_STATIONS; i++) begin
        present_q[i]   <= 1'b0;
        fail_safe_q[i] <= 1'b0;
        out_len_q[i]   <= '0;
      end
    end else if (new_hw_cfg) begin
      for (int i = 0; i < MAX_STATIONS; i++) begin
        present_q[i] <= 1'b0;
      end
    end else if (slave_cfg_wr && (slave_cfg.addr <= LAST_ADDR)) begin
      present_q[slave_cfg.addr]   <= slave_cfg.present;
      fail_safe_q[slave_cfg.addr] <= slave_cfg.fail_safe;
      out_len_q[slave_cfg.addr]   <= slave_cfg.out_len;
    end
  end

  // ************************************************************
  // Bit clock enable
  // ************************************************************
  // Freshly delivered parameters already set the first bit time after going online.
  wire [RATE_W-1:0] rate_sel = bus_par_valid ? bus_par.rate_idx : par_q.rate_idx;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (op_q == FMRS_OFF || div_q == 12'h001 || div_q == 12'h000) begin
      div_q <= fmrs_bit_div(rate_sel);
    end else begin
      div_q <= div_q - 12'h001;
    end
  end
  assign bit_tick = (op_q != FMRS_OFF) && (div_q == 12'h001);

  // ************************************************************
  // Bus cycle scheduler
  // ************************************************************
  always_comb begin
    cy_d = cy_q;
    case (cy_q)
      FMRS_CY_GLOBAL: if (tel_fire) cy_d = FMRS_CY_SLAVE;
      FMRS_CY_SLAVE:  if ((tel_fire || !cur_pres) && slot_last) cy_d = FMRS_CY_SELF;
      FMRS_CY_SELF:   if (tel_fire || !self_req) cy_d = FMRS_CY_GLOBAL;
      default:        cy_d = FMRS_CY_GLOBAL;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cy_q   <= FMRS_CY_GLOBAL;
      run_q  <= 1'b0;
      slot_q <= '0;
    end else if (op_q == FMRS_OFF) begin
      cy_q   <= FMRS_CY_GLOBAL;
      slot_q <= '0;
    end else begin
      cy_q <= (op_q == FMRS_EXCHANGE) ? cy_d : FMRS_CY_SELF;
      if (start_cyc) begin
        run_q <= host_run;
      end
      if (cy_q == FMRS_CY_SLAVE && (tel_fire || !cur_pres)) begin
        slot_q <= slot_last ? '0 : slot_q + 7'h01;
      end
    end
  end

  // Telegram builder: one register stage holds the offer until accepted.
  fmrs_tel_t tel_next;
  logic      tel_want;
  always_comb begin
    tel_next           = '0;
    tel_want           = 1'b0;
    tel_next.addr      = slot_q;
    case (cy_q)
      FMRS_CY_GLOBAL: begin
        tel_want      = (op_q == FMRS_EXCHANGE);
        tel_next.kind = FMRS_TG_GLOBAL;
        tel_next.gc   = host_run ? FMRS_GC_OPERATE : FMRS_GC_CLEAR;
      end
      FMRS_CY_SLAVE: begin
        tel_want           = cur_pres && (op_q == FMRS_EXCHANGE);
        tel_next.kind      = FMRS_TG_DATA;
        tel_next.len       = (!run_q && fail_safe_q[slot_q]) ? '0 : out_len_q[slot_q];
        tel_next.zero_data = !run_q;
      end
      FMRS_CY_SELF: begin
        tel_want      = self_req && (op_q != FMRS_OFF);
        tel_next.kind = FMRS_TG_SELF;
        tel_next.addr = par_q.own_addr;
      end
      default: tel_want = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tel_q       <= '0;
      tel_valid_q <= 1'b0;
    end else if (going_off) begin
      tel_valid_q <= 1'b0;
    end else if (tel_fire || !tel_valid_q) begin
      tel_q       <= tel_next;
      tel_valid_q <= tel_want && !tel_fire;
    end
  end

  assign tel       = tel_q;
  assign tel_valid = tel_valid_q;

  // ************************************************************
  // Input data path
  // ************************************************************
  fmrs_skid u_skid (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_data   (rx_word),
    .in_valid  (rx_valid && (op_q == FMRS_EXCHANGE)),
    .in_ready  (rx_ready),
    .out_data  (host_in),
    .out_valid (host_in_valid),
    .out_ready (host_in_ready)
  );

  assign run_led                 = (op_q != FMRS_OFF);
  assign data_exchange_indicator = (op_q == FMRS_EXCHANGE);
  assign master_active           = (op_q != FMRS_OFF);

  // ************************************************************
  // Assertions
  // ************************************************************
  a_dark_until_par: assert property (@(posedge clock) disable iff (!rst_n)
    (op_q == FMRS_OFF) |-> (!run_led && !data_exchange_indicator && !tel_valid))
    else $error("indicator lit while inactive");
  a_par_online: assert property (@(posedge clock) disable iff (!rst_n)
    (op_q == FMRS_OFF && bus_par_valid && !new_hw_cfg) |=> run_led)
    else $error("not online after bus parameters");
  a_self_addr: assert property (@(posedge clock) disable iff (!rst_n)
    (tel_valid && tel.kind == FMRS_TG_SELF) |-> (tel.addr == par_q.own_addr))
    else $error("self answer at wrong address");
  a_cfg_exchange: assert property (@(posedge clock) disable iff (!rst_n)
    (op_q == FMRS_ONLINE && cfg_done) |=> data_exchange_indicator)
    else $error("no exchange after configuration");
  a_new_cfg_off: assert property (@(posedge clock) disable iff (!rst_n)
    (op_q == FMRS_EXCHANGE && new_hw_cfg) |=> !data_exchange_indicator)
    else $error("no reload on new configuration");
  a_gc_match: assert property (@(posedge clock) disable iff (!rst_n)
    (tel_valid && tel.kind == FMRS_TG_GLOBAL && $stable(host_run) && $past(host_run) == 1'b0
     && $past(tel_valid) == 1'b0) |-> (tel.gc == FMRS_GC_CLEAR))
    else $error("Clear not sent in stop");
  a_fs_zero_len: assert property (@(posedge clock) disable iff (!rst_n)
    (tel_valid && tel.kind == FMRS_TG_DATA && tel.zero_data && fail_safe_q[tel.addr]) |-> (tel.len == '0))
    else $error("fail-safe slave got data in stop");
  a_nfs_full_len: assert property (@(posedge clock) disable iff (!rst_n)
    (tel_valid && tel.kind == FMRS_TG_DATA && !fail_safe_q[tel.addr]) |-> (tel.len == out_len_q[tel.addr]))
    else $error("non fail-safe length wrong");
  a_stop_inputs: assert property (@(posedge clock) disable iff (!rst_n)
    (data_exchange_indicator && rx_valid && !host_in_valid) |=> host_in_valid)
    else $error("inputs dropped");
  a_run_data: assert property (@(posedge clock) disable iff (!rst_n)
    (tel_valid && tel.kind == FMRS_TG_DATA) |-> (tel.zero_data == !run_q))
    else $error("output data mode mismatch");
  c_exchange: cover property (@(posedge clock) disable iff (!rst_n) op_q == FMRS_ONLINE ##1 op_q == FMRS_EXCHANGE);
  c_clear: cover property (@(posedge clock) disable iff (!rst_n) tel_fire && tel.gc == FMRS_GC_CLEAR);
  c_operate: cover property (@(posedge clock) disable iff (!rst_n) tel_fire && tel.gc == FMRS_GC_OPERATE);
  c_full: cover property (@(posedge clock) disable iff (!rst_n) !rx_ready);
endmodule : fmrs_ctrl

// ---- testbench/fmrs_slave_model.sv ----
// Purpose: Telegram engine and slave stand-in at the far side of the master.
// Assumes: One clock; each data telegram returns one input word, in order.
// Notes:   Slow mode accepts a telegram only every other cycle.
`timescale 1ns/1ns
module fmrs_slave_model (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    slow,
  input  wire fmrs_pkg::fmrs_tel_t     tel,
  input  wire logic                    tel_valid,
  output logic                         tel_ready,
  output fmrs_pkg::fmrs_in_word_t      rx_word,
  output logic                         rx_valid,
  input  wire logic                    rx_ready,
  output logic                         outs_on
);
  import fmrs_pkg::*;
  // ****************************************
  // Slave behaviour; no rate is configured here, the model follows the master.
  // ****************************************
  fmrs_in_word_t q [$];
  fmrs_in_word_t w;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tel_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_word <= '0;
      outs_on <= 1'b0;
      q = {};
    end else begin
      if (rx_valid && rx_ready) void'(q.pop_front());
      if (tel_valid && tel_ready && tel.kind == FMRS_TG_GLOBAL) outs_on <= (tel.gc == FMRS_GC_OPERATE);
      if (tel_valid && tel_ready && tel.kind == FMRS_TG_DATA) begin
        w.addr = tel.addr;
        w.data = {1'b0, tel.addr} ^ 8'h5a;
        w.idx = 8'h00;
        q.push_back(w);
      end
      tel_ready <= slow ? ~tel_ready : 1'b1;
      rx_valid <= (q.size() > 0);
      rx_word <= (q.size() > 0) ? q[0] : ~rx_word;
    end
  end
endmodule : fmrs_slave_model

// ---- testbench/fmrs_ctrl_bench.sv ----
// Purpose: Self-checking bench for the run/stop control of the fieldbus master.
// Assumes: Inputs change at the falling edge; the slave model answers telegrams.
// Notes:   Slaves sit at addresses 3 and 125.
`timescale 1ns/1ns
module fmrs_ctrl_bench;
  import fmrs_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic            clock, rst_n, new_hw_cfg, bus_par_valid, slave_cfg_wr, cfg_done;
  logic            host_run, self_req, host_in_ready, slow, tel_valid, tel_ready, bit_tick;
  logic            rx_valid, rx_ready, host_in_valid, run_led, dx_led, master_active, outs_on;
  fmrs_bus_par_t   bus_par;
  fmrs_slave_cfg_t slave_cfg;
  fmrs_tel_t       tel, t;
  fmrs_in_word_t   rx_word, host_in;
  fmrs_tel_t       tq [$];
  fmrs_in_word_t   hq [$];
  int              errors, num_checks, n;
  fmrs_ctrl dut (.clock(clock), .rst_n(rst_n), .new_hw_cfg(new_hw_cfg), .bus_par(bus_par),
    .bus_par_valid(bus_par_valid), .slave_cfg(slave_cfg), .slave_cfg_wr(slave_cfg_wr), .cfg_done(cfg_done),
    .host_run(host_run), .tel(tel), .tel_valid(tel_valid), .tel_ready(tel_ready), .self_req(self_req),
    .bit_tick(bit_tick), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready), .host_in(host_in),
    .host_in_valid(host_in_valid), .host_in_ready(host_in_ready), .run_led(run_led),
    .data_exchange_indicator(dx_led), .master_active(master_active));
  fmrs_slave_model slv (.clock(clock), .rst_n(rst_n), .slow(slow), .tel(tel), .tel_valid(tel_valid),
    .tel_ready(tel_ready), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready), .outs_on(outs_on));
  always @(posedge clock) begin
    if (tel_valid && tel_ready) tq.push_back(tel);
    if (host_in_valid && host_in_ready) hq.push_back(host_in);
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task conclude();
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task cyc(input int k);
    repeat (k) @(negedge clock);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask : pulse
  task get_tel(input fmrs_tg_t k);
    int w;
    w = 0;
    while ((tq.size() == 0 || tq[0].kind != k) && w < 600) begin
      if (tq.size() > 0) void'(tq.pop_front());
      else begin
        cyc(1);
        w++;
      end
    end
    if (tq.size() == 0 || tq[0].kind != k) begin
      errors++;
      conclude();
    end
    t = tq.pop_front();
  endtask : get_tel
  task wait_hq(input int k);
    int w;
    for (w = 0; w < 600 && hq.size() < k; w++) cyc(1);
    if (hq.size() < k) begin
      errors++;
      conclude();
    end
  endtask : wait_hq
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset();
    chk({run_led, dx_led, master_active, tel_valid, rx_ready}, 5'h01);
    pulse(cfg_done);
    cyc(2);
    chk({run_led, dx_led}, 2'h0);
  endtask : t_reset
  task t_online();
    bus_par = '{own_addr: 7'h11, rate_idx: 4'h4};
    pulse(bus_par_valid);
    chk({run_led, master_active}, 2'h3);
    n = 0;
    repeat (130) begin
      cyc(1);
      n += (bit_tick === 1'b1);
    end
    chk(n, 10);
    tq = {};
    self_req = 1'b1;
    get_tel(FMRS_TG_SELF);
    chk(t.addr, 7'h11);
    self_req = 1'b0;
  endtask : t_online
  task t_stop_run();
    slave_cfg = '{addr: 7'h03, present: 1'b1, fail_safe: 1'b1, out_len: 8'h04};
    pulse(slave_cfg_wr);
    slave_cfg = '{addr: 7'h7d, present: 1'b1, fail_safe: 1'b0, out_len: 8'h02};
    pulse(slave_cfg_wr);
    hq = {};
    tq = {};
    pulse(cfg_done);
    chk({dx_led, run_led}, 2'h3);
    get_tel(FMRS_TG_GLOBAL);
    chk(t.gc, FMRS_GC_CLEAR);
    get_tel(FMRS_TG_DATA);
    chk({t.addr, t.len, t.zero_data}, {7'h03, 8'h00, 1'b1});
    get_tel(FMRS_TG_DATA);
    chk({t.addr, t.len, t.zero_data}, {7'h7d, 8'h02, 1'b1});
    chk(outs_on, 1'b0);
    wait_hq(2);
    chk({hq[0].addr, hq[0].data, hq[1].addr}, {7'h03, 8'h59, 7'h7d});
    host_run = 1'b1;
    get_tel(FMRS_TG_GLOBAL);
    if (t.gc === FMRS_GC_CLEAR) get_tel(FMRS_TG_GLOBAL);
    chk(t.gc, FMRS_GC_OPERATE);
    get_tel(FMRS_TG_DATA);
    chk({t.addr, t.len, t.zero_data}, {7'h03, 8'h04, 1'b0});
    get_tel(FMRS_TG_DATA);
    chk({t.addr, t.len, t.zero_data}, {7'h7d, 8'h02, 1'b0});
    cyc(2);
    chk(outs_on, 1'b1);
  endtask : t_stop_run
  task t_buffer();
    int i;
    slow = 1'b1;
    host_in_ready = 1'b0;
    cyc(1);
    hq = {};
    for (i = 0; i < 600 && rx_ready !== 1'b0; i++) cyc(1);
    chk(rx_ready, 1'b0);
    cyc(20);
    host_in_ready = 1'b1;
    wait_hq(6);
    for (i = 0; i < 6; i++) chk({hq[i].data, hq[i].idx}, {{1'b0, hq[i].addr} ^ 8'h5a, 8'h00});
    for (i = 2; i < 6; i++) chk(hq[i].addr, hq[i-2].addr);
    chk(hq[0].addr ^ hq[1].addr, 7'h7e);
    slow = 1'b0;
  endtask : t_buffer
  task t_newcfg();
    pulse(new_hw_cfg);
    chk({run_led, dx_led, master_active}, 3'h0);
    pulse(bus_par_valid);
    chk(run_led, 1'b1);
    pulse(cfg_done);
    tq = {};
    cyc(60);
    n = 0;
    foreach (tq[i]) n += (tq[i].kind === FMRS_TG_DATA);
    chk(n, 0);
    chk(tq.size() > 0, 1'b1);
  endtask : t_newcfg
  // ****************************************
  // Clock, reset and sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    {rst_n, new_hw_cfg, bus_par_valid, slave_cfg_wr, cfg_done, host_run, self_req, slow} = '0;
    host_in_ready = 1'b1;
    bus_par = '0;
    slave_cfg = '0;
    errors = 0;
    num_checks = 0;
    cyc(4);
    rst_n = 1'b1;
    cyc(1);
    t_reset();
    t_online();
    t_stop_run();
    t_buffer();
    t_newcfg();
    conclude();
  end
endmodule : fmrs_ctrl_bench
